// [eeprom_seq_defines.vh]
/*
  offsets, field positions, command codes and timing counts of the
  eeprom command sequencer. assumes a 32-bit classic wishbone slave with
  byte offsets and a 10 MHz system clock.
*/
`ifndef EEPROM_SEQ_DEFINES_VH
`define EEPROM_SEQ_DEFINES_VH

// ==========================================================
// register byte offsets
`define OFS_PARAM_INDEX   8'h00
`define OFS_PARAM_DATA    8'h04
`define OFS_STATUS        8'h08
`define OFS_CONFIG        8'h0C
`define OFS_ERR_STATUS    8'h10
`define OFS_ERR_CONFIG    8'h14
`define OFS_MODE_CTRL     8'h18
`define OFS_IRQ_STATUS    8'h1C
`define OFS_IRQ_MASK      8'h20

// ==========================================================
// status fields
`define ST_COMPLETE_BIT   7
`define ST_ACCESS_ERR_BIT 5
`define ST_PROTECT_BIT    4
`define ST_BUSY_BIT       3
`define ST_MARGIN_HI_BIT  1
`define ST_MARGIN_LO_BIT  0

// ==========================================================
// command codes and parameter indices
`define CMD_ERASE_VERIFY  8'h10
`define CMD_PROGRAM       8'h11
`define CMD_SECTOR_ERASE  8'h12
`define IDX_ADDR          3'h1
`define IDX_COUNT         3'h2
`define IDX_LAST_WORD     3'h5
`define EE_BLOCK_HI       2'h0
`define EE_LAST_WORD      16'h0FFE
`define EE_SECTOR_MASK    16'hFFFC

// ==========================================================
// timing, in nanoseconds, and the clock period
`define CLK_PERIOD_NS     100
`define PROG_TIME_NS      3000
`define ERASE_TIME_NS     20000
`define PROG_CYCLES  ((`PROG_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ERASE_CYCLES ((`ERASE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// [eeprom_command_sequencer_irq.v]
/*
  command sequencer for the data eeprom: erase-verify section, program
  one to four words, sector erase, with status flags and interrupts.
  assumes a classic wishbone master and an eeprom array port that
  answers a read while mem_rd_o is high, with data and ecc flags.
*/
// Overview of operation
// - erase-verify code 10, slot 2 holds count
// - erase-verify checks blank, sets complete flag
// - erase-verify needs index 010 or access error
// - bad, odd or overrunning section gives access error
// - single read errors set margin hi, double set hi and lo
// - program code 11, words in slots 2..5
// - launch index sets word count, range 010..101
// - overrunning, invalid or odd address gives access error
// - protected area blocks program, sets violation flag
// - program verifies words, margin bits, then complete
// - sector erase code 12, index must be 001
// - sector erase then blank verify, then complete
// - command not allowed in mode gives access error
// - command irq when complete flag and enable
// - error irq from ecc fault flags with enables
// - wait mode leaves running command untouched
// - stop waits until running command finishes
`include "eeprom_seq_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module eeprom_command_sequencer_irq (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [7:0]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output wire [31:0] dat_o,
  output wire        ack_o,
  input  wire        cmd_allowed_i,
  input  wire        area_protected_i,
  input  wire        stop_req_i,
  output wire        stop_ack_o,
  output reg         mem_rd_o,
  output reg         mem_wr_o,
  output reg         mem_erase_o,
  output reg  [15:0] mem_addr_o,
  output reg  [15:0] mem_wdata_o,
  input  wire [15:0] mem_rdata_i,
  input  wire        mem_ecc_single_i,
  input  wire        mem_ecc_double_i,
  output wire        cmd_irq_o,
  output wire        err_irq_o,
  output wire        irq_o
);

  // ==========================================================
  // states
  localparam [5:0] S_IDLE  = 6'h01;
  localparam [5:0] S_READ  = 6'h02;
  localparam [5:0] S_CHECK = 6'h04;
  localparam [5:0] S_PROG  = 6'h08;
  localparam [5:0] S_ERASE = 6'h10;
  localparam [5:0] S_DONE  = 6'h20;
  localparam [31:0] PROG_CYC  = `PROG_CYCLES;
  localparam [31:0] ERASE_CYC = `ERASE_CYCLES;
  localparam [15:0] PROG_CNT  = PROG_CYC[15:0];
  localparam [15:0] ERASE_CNT = ERASE_CYC[15:0];

  reg  [15:0] command_param_bank [0:5];
  reg  [2:0]  param_index_ff;
  reg  [5:0]  state_ff;
  reg  [7:0]  cmd_ff;
  reg  [15:0] addr_ff;
  reg  [15:0] left_ff;
  reg  [2:0]  word_ff;
  reg  [15:0] timer_ff;
  reg         cmd_complete_flag_ff;
  reg         access_error_flag_ff;
  reg         protect_violation_flag_ff;
  reg  [1:0]  margin_status_ff;
  reg         cmd_complete_irq_en_ff;
  reg         double_fault_flag_ff;
  reg         single_fault_flag_ff;
  reg         double_fault_irq_en_ff;
  reg         single_fault_irq_en_ff;
  reg         wait_mode_ff;
  reg  [2:0]  irq_status_ff;
  reg  [2:0]  irq_mask_ff;
  reg         ack_ff;
  reg  [31:0] dat_ff;
  reg         cmd_done_prev_ff;

  // ==========================================================
  // bus decode; one-cycle registered ack
  wire req     = cyc_i & stb_i & ~ack_ff;
  wire wr_lo   = req & we_i & sel_i[0];
  wire wr_hi   = req & we_i & sel_i[1];
  wire wr_stat = wr_lo & (adr_i == `OFS_STATUS);
  wire launch  = wr_stat & dat_i[`ST_COMPLETE_BIT] & cmd_complete_flag_ff;
  assign ack_o = ack_ff;
  assign dat_o = dat_ff;

  // ==========================================================
  // launch checks
  wire [15:0] p0     = command_param_bank[0];
  wire [15:0] p1     = command_param_bank[1];
  wire [7:0]  code   = p0[15:8];
  wire        bad_hi = (p0[1:0] != `EE_BLOCK_HI);
  wire        odd    = p1[0];
  wire [15:0] ev_end = p1 + {command_param_bank[2][14:0], 1'b0} - 16'h0002;
  wire [15:0] pg_end = p1 + {12'h000, param_index_ff - `IDX_COUNT, 1'b0};
  wire        ev_err = (param_index_ff != `IDX_COUNT) |
                       (command_param_bank[2] == 16'h0000) |
                       (ev_end > `EE_LAST_WORD) | (ev_end < p1);
  wire        pg_err = (param_index_ff < `IDX_COUNT) |
                       (param_index_ff > `IDX_LAST_WORD) |
                       (p1 > `EE_LAST_WORD) |
                       (pg_end > `EE_LAST_WORD);
  wire        se_err = (param_index_ff != `IDX_ADDR) |
                       (p1 > `EE_LAST_WORD);
  wire        known  = (code == `CMD_ERASE_VERIFY) |
                       (code == `CMD_PROGRAM) |
                       (code == `CMD_SECTOR_ERASE);
  reg         acc_err;
  always @* begin
    case (code)
      `CMD_ERASE_VERIFY: acc_err = ev_err;
      `CMD_PROGRAM:      acc_err = pg_err;
      `CMD_SECTOR_ERASE: acc_err = se_err;
      default:           acc_err = 1'b1;
    endcase
    // mode filter and common address checks
    acc_err = acc_err | ~cmd_allowed_i | bad_hi | odd | ~known;
  end
  wire prot_err = ~acc_err & area_protected_i &
                  (code != `CMD_ERASE_VERIFY);

  // ==========================================================
  // sequencer; wait mode is only a flag, nothing here looks at it
  wire blank_fail = (mem_rdata_i != 16'hFFFF);
  wire rd_err     = mem_ecc_single_i | mem_ecc_double_i;
  wire cmd_done   = cmd_complete_flag_ff;
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_ff                  <= S_IDLE;
      cmd_ff                    <= 8'h00;
      addr_ff                   <= 16'h0000;
      left_ff                   <= 16'h0000;
      word_ff                   <= 3'h0;
      timer_ff                  <= 16'h0000;
      cmd_complete_flag_ff      <= 1'b1;
      access_error_flag_ff      <= 1'b0;
      protect_violation_flag_ff <= 1'b0;
      margin_status_ff          <= 2'h0;
      double_fault_flag_ff      <= 1'b0;
      single_fault_flag_ff      <= 1'b0;
      mem_rd_o                  <= 1'b0;
      mem_wr_o                  <= 1'b0;
      mem_erase_o               <= 1'b0;
      mem_addr_o                <= 16'h0000;
      mem_wdata_o               <= 16'h0000;
    end else begin
      mem_rd_o    <= 1'b0;
      mem_wr_o    <= 1'b0;
      mem_erase_o <= 1'b0;
      // error flags clear on write-one; a flag set in the same cycle wins
      if (wr_stat & dat_i[`ST_ACCESS_ERR_BIT])
        access_error_flag_ff <= 1'b0;
      if (wr_stat & dat_i[`ST_PROTECT_BIT])
        protect_violation_flag_ff <= 1'b0;
      if (wr_lo & (adr_i == `OFS_ERR_STATUS)) begin
        if (dat_i[1])
          double_fault_flag_ff <= 1'b0;
        if (dat_i[0])
          single_fault_flag_ff <= 1'b0;
      end
      case (state_ff)
        S_IDLE: begin
          if (launch) begin
            cmd_complete_flag_ff <= 1'b0;
            margin_status_ff     <= 2'h0;
            cmd_ff               <= code;
            word_ff              <= 3'h2;
            if (acc_err | prot_err) begin
              access_error_flag_ff      <= acc_err;
              protect_violation_flag_ff <= prot_err;
              state_ff <= S_DONE;
            end else if (code == `CMD_SECTOR_ERASE) begin
              addr_ff     <= p1 & `EE_SECTOR_MASK;
              mem_addr_o  <= p1 & `EE_SECTOR_MASK;
              mem_erase_o <= 1'b1;
              left_ff     <= 16'h0002;
              timer_ff    <= ERASE_CNT;
              state_ff    <= S_ERASE;
            end else if (code == `CMD_PROGRAM) begin
              addr_ff     <= p1;
              mem_addr_o  <= p1;
              mem_wdata_o <= command_param_bank[2];
              mem_wr_o    <= 1'b1;
              left_ff     <= {13'h0000, param_index_ff - 3'h1};
              timer_ff    <= PROG_CNT;
              state_ff    <= S_PROG;
            end else begin
              addr_ff    <= p1;
              mem_addr_o <= p1;
              mem_rd_o   <= 1'b1;
              left_ff    <= command_param_bank[2];
              state_ff   <= S_CHECK;
            end
          end
        end
        S_PROG, S_ERASE: begin
          timer_ff <= timer_ff - 16'h0001;
          if (timer_ff == 16'h0001) begin
            mem_addr_o <= addr_ff;
            mem_rd_o   <= 1'b1;
            state_ff   <= S_CHECK;
          end
        end
        S_READ: begin
          mem_addr_o <= addr_ff;
          mem_rd_o   <= 1'b1;
          state_ff   <= S_CHECK;
        end
        S_CHECK: begin
          if (mem_ecc_double_i)
            double_fault_flag_ff <= 1'b1;
          if (mem_ecc_single_i)
            single_fault_flag_ff <= 1'b1;
          if (cmd_ff == `CMD_PROGRAM) begin
            if (mem_rdata_i != command_param_bank[word_ff] | rd_err)
              margin_status_ff[1] <= 1'b1;
          end else if (blank_fail | mem_ecc_double_i)
            margin_status_ff <= 2'h3;
          else if (mem_ecc_single_i)
            margin_status_ff[1] <= 1'b1;
          if (mem_ecc_double_i)
            margin_status_ff[0] <= 1'b1;
          addr_ff  <= addr_ff + 16'h0002;
          left_ff  <= left_ff - 16'h0001;
          if (left_ff == 16'h0001)
            state_ff <= S_DONE;
          else if (cmd_ff == `CMD_PROGRAM) begin
            // next word: program, then verify it
            word_ff     <= word_ff + 3'h1;
            mem_addr_o  <= addr_ff + 16'h0002;
            mem_wdata_o <= command_param_bank[word_ff + 3'h1];
            mem_wr_o    <= 1'b1;
            timer_ff    <= PROG_CNT;
            state_ff    <= S_PROG;
          end else
            state_ff <= S_READ;
        end
        S_DONE: begin
          cmd_complete_flag_ff <= 1'b1;
          state_ff             <= S_IDLE;
        end
        default: state_ff <= S_IDLE;
      endcase
    end
  end

  // ==========================================================
  // parameter bank, config registers, interrupt block
  always @(posedge clk_i) begin
    if (rst_i) begin
      param_index_ff         <= 3'h0;
      cmd_complete_irq_en_ff <= 1'b0;
      double_fault_irq_en_ff <= 1'b0;
      single_fault_irq_en_ff <= 1'b0;
      wait_mode_ff           <= 1'b0;
      irq_status_ff          <= 3'h0;
      irq_mask_ff            <= 3'h0;
      cmd_done_prev_ff       <= 1'b1;
      ack_ff                 <= 1'b0;
      dat_ff                 <= 32'h0000_0000;
    end else begin
      ack_ff           <= req;
      cmd_done_prev_ff <= cmd_done;
      // parameters only change while no command runs
      if (wr_lo & cmd_done & (adr_i == `OFS_PARAM_INDEX))
        param_index_ff <= dat_i[2:0];
      if (wr_lo & (adr_i == `OFS_CONFIG))
        cmd_complete_irq_en_ff <= dat_i[7];
      if (wr_lo & (adr_i == `OFS_ERR_CONFIG)) begin
        double_fault_irq_en_ff <= dat_i[1];
        single_fault_irq_en_ff <= dat_i[0];
      end
      if (wr_lo & (adr_i == `OFS_MODE_CTRL))
        wait_mode_ff <= dat_i[0];
      if (wr_lo & (adr_i == `OFS_IRQ_MASK))
        irq_mask_ff <= dat_i[2:0];
      // sticky events: set beats write-one clear
      irq_status_ff <= (irq_status_ff &
                        ~((wr_lo & (adr_i == `OFS_IRQ_STATUS)) ?
                          dat_i[2:0] : 3'h0)) |
                       {double_fault_flag_ff, single_fault_flag_ff,
                        cmd_done & ~cmd_done_prev_ff};
      case (adr_i)
        `OFS_PARAM_INDEX: dat_ff <= {29'h0, param_index_ff};
        `OFS_PARAM_DATA:
          dat_ff <= (param_index_ff > 3'h5) ? 32'h0 :
                    {16'h0, command_param_bank[param_index_ff]};
        `OFS_STATUS:
          dat_ff <= {24'h0, cmd_complete_flag_ff, 1'b0,
                     access_error_flag_ff, protect_violation_flag_ff,
                     ~cmd_done, 1'b0, margin_status_ff};
        `OFS_CONFIG:      dat_ff <= {24'h0, cmd_complete_irq_en_ff, 7'h0};
        `OFS_ERR_STATUS:
          dat_ff <= {30'h0, double_fault_flag_ff, single_fault_flag_ff};
        `OFS_ERR_CONFIG:
          dat_ff <= {30'h0, double_fault_irq_en_ff, single_fault_irq_en_ff};
        `OFS_MODE_CTRL:   dat_ff <= {31'h0, wait_mode_ff};
        `OFS_IRQ_STATUS:  dat_ff <= {29'h0, irq_status_ff};
        `OFS_IRQ_MASK:    dat_ff <= {29'h0, irq_mask_ff};
        default:          dat_ff <= 32'h0000_0000;
      endcase
    end
  end

  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : g_bank
      always @(posedge clk_i) begin
        if (rst_i) begin
          command_param_bank[g] <= 16'h0000;
        end else if (cmd_done & (adr_i == `OFS_PARAM_DATA) &
                     (param_index_ff == g)) begin
          if (wr_lo)
            command_param_bank[g][7:0] <= dat_i[7:0];
          if (wr_hi)
            command_param_bank[g][15:8] <= dat_i[15:8];
        end
      end
    end
  endgenerate

  assign cmd_irq_o  = cmd_complete_flag_ff & cmd_complete_irq_en_ff;
  assign err_irq_o  = (double_fault_flag_ff & double_fault_irq_en_ff) |
                      (single_fault_flag_ff & single_fault_irq_en_ff);
  assign irq_o      = |(irq_status_ff & irq_mask_ff);
  // stop is granted only when no command is running
  assign stop_ack_o = stop_req_i & cmd_done;

endmodule // eeprom_command_sequencer_irq

`default_nettype wire

// [eeprom_seq_asserts.sv]
/*
  checker: bus answer, memory strobe, stop and irq relations of the
  eeprom command sequencer. assumes it is bound onto the top module.
*/
`timescale 1ns/1ps
`default_nettype none
module eeprom_seq_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic stop_req_i,
  input wire logic stop_ack_o,
  input wire logic mem_rd_o,
  input wire logic mem_wr_o,
  input wire logic mem_erase_o,
  input wire logic cmd_irq_o
);
  // ==========================================================
  // properties
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic busy_w = mem_rd_o | mem_wr_o | mem_erase_o;

  property p_ack_once;
    cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once)
    else $error("bus answer not a single pulse after one cycle");
  // a verify read may be followed at once by the next word's program
  property p_strobe_pulse;
    busy_w |=> !mem_rd_o && !mem_erase_o && !(mem_wr_o && $past(mem_wr_o));
  endproperty
  a_strobe_pulse: assert property (p_strobe_pulse)
    else $error("memory strobe longer than one cycle");
  property p_one_strobe;
    $onehot0({mem_rd_o, mem_wr_o, mem_erase_o});
  endproperty
  a_one_strobe: assert property (p_one_strobe)
    else $error("two memory strobes at once");
  property p_erase_first; mem_erase_o |=> !mem_rd_o [*8]; endproperty
  a_erase_first: assert property (p_erase_first)
    else $error("blank read too soon after erase");
  property p_prog_verify; mem_wr_o |-> ##[2:200] mem_rd_o; endproperty
  a_prog_verify: assert property (p_prog_verify)
    else $error("no read back after program");
  property p_stop_hold; stop_req_i && busy_w |-> !stop_ack_o; endproperty
  a_stop_hold: assert property (p_stop_hold)
    else $error("stop granted while command runs");
  property p_stop_level; !stop_req_i |-> !stop_ack_o; endproperty
  a_stop_level: assert property (p_stop_level)
    else $error("stop granted without request");
  property p_irq_busy; busy_w |-> !cmd_irq_o; endproperty
  a_irq_busy: assert property (p_irq_busy)
    else $error("command irq while command runs");
endmodule // eeprom_seq_asserts

bind eeprom_command_sequencer_irq eeprom_seq_asserts i_eeprom_seq_asserts (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .ack_o(ack_o), .stop_req_i(stop_req_i), .stop_ack_o(stop_ack_o),
  .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o), .mem_erase_o(mem_erase_o),
  .cmd_irq_o(cmd_irq_o));
`default_nettype wire

// [eeprom_command_sequencer_irq_tb.sv]
/*
  testbench: drives wishbone and models the eeprom array.
  assumes the defines header and a 10 MHz clock.
*/
`include "eeprom_seq_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module eeprom_command_sequencer_irq_tb;
  logic        clk_i = 1'b0, rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, ack_o;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0, q, dat_o;
  logic        allowed = 1'b1, prot = 1'b0, stop = 1'b0, stop_ack_o;
  logic        inj_s = 1'b0, inj_d = 1'b0, ecc_s, ecc_d;
  logic        mem_rd_o, mem_wr_o, mem_erase_o;
  logic        cmd_irq_o, err_irq_o, irq_o;
  logic [15:0] mem_addr_o, mem_wdata_o, rdata;
  logic [15:0] mem [0:2047];
  int          fail_count = 0, check_count = 0, i;

  always #50 clk_i = ~clk_i;

  eeprom_command_sequencer_irq i_eeprom_command_sequencer_irq (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(4'h3), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
    .cmd_allowed_i(allowed), .area_protected_i(prot),
    .stop_req_i(stop), .stop_ack_o(stop_ack_o), .mem_rd_o(mem_rd_o),
    .mem_wr_o(mem_wr_o), .mem_erase_o(mem_erase_o),
    .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
    .mem_rdata_i(rdata), .mem_ecc_single_i(ecc_s),
    .mem_ecc_double_i(ecc_d), .cmd_irq_o(cmd_irq_o),
    .err_irq_o(err_irq_o), .irq_o(irq_o));

  // ==========================================================
  // array model: a read answers while mem_rd_o is high, as the sequencer
  // samples it; idle data is the inverse so stale data never matches
  always @(posedge clk_i) begin
    if (mem_wr_o) mem[mem_addr_o[11:1]] <= mem_wdata_o;
    if (mem_erase_o) begin
      mem[{mem_addr_o[11:2], 1'b0}] <= 16'hFFFF;
      mem[{mem_addr_o[11:2], 1'b1}] <= 16'hFFFF;
    end
  end
  assign rdata = mem_rd_o ? mem[mem_addr_o[11:1]] : ~mem[mem_addr_o[11:1]];
  assign ecc_s = mem_rd_o & inj_s;
  assign ecc_d = mem_rd_o & inj_d;

  // ==========================================================
  // tasks
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (ack_o !== 1'b1) fail_count++;
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask

  // pins are judged at the falling edge, after the write has landed
  task automatic pin_chk(input logic got_now, input logic exp);
    @(negedge clk_i);
    chk({31'h0, got_now}, {31'h0, exp});
    @(posedge clk_i);
  endtask

  task automatic mem_chk(input logic [15:0] a, input logic [15:0] exp);
    chk({16'h0, mem[a[11:1]]}, {16'h0, exp});
  endtask

  task automatic load(input logic [7:0] c, input logic [15:0] a,
                      input int last, input logic [15:0] d);
    int k;
    logic [15:0] v;
    for (k = 0; k <= last; k++) begin
      v = (k == 0) ? {c, 8'h00} : (k == 1) ? a : d + 16'(k - 2);
      wb(1'b1, `OFS_PARAM_INDEX, 32'(k));
      wb(1'b1, `OFS_PARAM_DATA, {16'h0, v});
    end
  endtask

  task automatic wait_done;
    int n;
    n = 0;
    do begin
      wb(1'b0, `OFS_STATUS, 32'h0);
      n++;
    end while (q[7] !== 1'b1 && n < 500);
    if (q[7] !== 1'b1) fail_count++;
  endtask

  task automatic cmd(input logic [7:0] c, input logic [15:0] a,
                     input int last, input logic [15:0] d);
    load(c, a, last, d);
    wb(1'b1, `OFS_STATUS, 32'h80);
    wait_done;
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ==========================================================
  // access error table: code, address, last index, data
  // the last two: an undecoded code and a sector past the block end
  logic [7:0]  e_c [11] = '{8'h10, 8'h10, 8'h10, 8'h11, 8'h11, 8'h11,
                            8'h11, 8'h12, 8'h12, 8'h13, 8'h12};
  logic [15:0] e_a [11] = '{16'h0010, 16'h0011, 16'h0FFC, 16'h0010,
                            16'h0010, 16'h0FFC, 16'h0021, 16'h0010,
                            16'h0011, 16'h0010, 16'h1000};
  int          e_l [11] = '{1, 2, 2, 1, 6, 5, 2, 2, 1, 1, 1};
  logic [15:0] e_d [11] = '{16'h4, 16'h2, 16'h3, 16'h0, 16'h0, 16'h0,
                            16'h0, 16'h0, 16'h0, 16'h0, 16'h0};

  initial begin
    #6000000;
    fail_count++;
    wrap_up;
  end

  initial begin
    for (i = 0; i < 2048; i++) mem[i] = 16'hFFFF;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(`OFS_STATUS, 32'h80);
    rd_chk(8'h3C, 32'h0);
    pin_chk(irq_o, 1'b0);
    $display("test reset done");
    for (i = 0; i < 11; i++) begin
      cmd(e_c[i], e_a[i], e_l[i], e_d[i]);
      rd_chk(`OFS_STATUS, 32'hA0);
      wb(1'b1, `OFS_STATUS, 32'h30);
    end
    allowed <= 1'b0;
    cmd(8'h10, 16'h0010, 2, 16'h2);
    rd_chk(`OFS_STATUS, 32'hA0);
    wb(1'b1, `OFS_STATUS, 32'h30);
    allowed <= 1'b1;
    mem_chk(16'h0010, 16'hFFFF);
    $display("test launch errors done");
    cmd(8'h11, 16'h0010, 3, 16'h1234);
    rd_chk(`OFS_STATUS, 32'h80);
    mem_chk(16'h0010, 16'h1234);
    mem_chk(16'h0012, 16'h1235);
    mem_chk(16'h0014, 16'hFFFF);
    cmd(8'h10, 16'h0010, 2, 16'h2);
    rd_chk(`OFS_STATUS, 32'h83);
    cmd(8'h10, 16'h0014, 2, 16'h2);
    rd_chk(`OFS_STATUS, 32'h80);
    $display("test program verify done");
    prot <= 1'b1;
    cmd(8'h11, 16'h0020, 2, 16'h5555);
    rd_chk(`OFS_STATUS, 32'h90);
    mem_chk(16'h0020, 16'hFFFF);
    wb(1'b1, `OFS_STATUS, 32'h30);
    cmd(8'h12, 16'h0010, 1, 16'h0);
    rd_chk(`OFS_STATUS, 32'h90);
    mem_chk(16'h0010, 16'h1234);
    wb(1'b1, `OFS_STATUS, 32'h30);
    prot <= 1'b0;
    $display("test protection done");
    wb(1'b1, `OFS_MODE_CTRL, 32'h1);
    wb(1'b1, `OFS_CONFIG, 32'h80);
    stop <= 1'b1;
    load(8'h12, 16'h0012, 1, 16'h0);
    wb(1'b1, `OFS_STATUS, 32'h80);
    // while the erase runs: busy, no stop grant, no irq, index locked
    rd_chk(`OFS_STATUS, 32'h08);
    pin_chk(stop_ack_o, 1'b0);
    pin_chk(cmd_irq_o, 1'b0);
    wb(1'b1, `OFS_PARAM_INDEX, 32'h3);
    wait_done;
    rd_chk(`OFS_STATUS, 32'h80);
    rd_chk(`OFS_PARAM_INDEX, 32'h1);
    mem_chk(16'h0010, 16'hFFFF);
    mem_chk(16'h0012, 16'hFFFF);
    pin_chk(stop_ack_o, 1'b1);
    pin_chk(cmd_irq_o, 1'b1);
    stop <= 1'b0;
    wb(1'b1, `OFS_CONFIG, 32'h0);
    pin_chk(cmd_irq_o, 1'b0);
    $display("test erase and wait done");
    wb(1'b1, `OFS_ERR_CONFIG, 32'h1);
    inj_s <= 1'b1;
    cmd(8'h10, 16'h0040, 2, 16'h2);
    rd_chk(`OFS_STATUS, 32'h82);
    rd_chk(`OFS_ERR_STATUS, 32'h1);
    pin_chk(err_irq_o, 1'b1);
    wb(1'b1, `OFS_ERR_CONFIG, 32'h0);
    pin_chk(err_irq_o, 1'b0);
    wb(1'b1, `OFS_ERR_STATUS, 32'h3);
    inj_s <= 1'b0;
    inj_d <= 1'b1;
    wb(1'b1, `OFS_ERR_CONFIG, 32'h2);
    cmd(8'h10, 16'h0040, 2, 16'h2);
    inj_d <= 1'b0;
    rd_chk(`OFS_STATUS, 32'h83);
    rd_chk(`OFS_ERR_STATUS, 32'h2);
    pin_chk(err_irq_o, 1'b1);
    wb(1'b1, `OFS_ERR_STATUS, 32'h3);
    pin_chk(err_irq_o, 1'b0);
    $display("test ecc faults done");
    wb(1'b1, `OFS_IRQ_STATUS, 32'h7);
    wb(1'b1, `OFS_IRQ_MASK, 32'h1);
    pin_chk(irq_o, 1'b0);
    cmd(8'h10, 16'h0040, 2, 16'h2);
    pin_chk(irq_o, 1'b1);
    wb(1'b1, `OFS_IRQ_MASK, 32'h0);
    pin_chk(irq_o, 1'b0);
    wb(1'b1, `OFS_IRQ_MASK, 32'h1);
    wb(1'b1, `OFS_IRQ_STATUS, 32'h1);
    pin_chk(irq_o, 1'b0);
    rd_chk(`OFS_IRQ_STATUS, 32'h0);
    $display("test interrupt done");
    wrap_up;
  end
endmodule // eeprom_command_sequencer_irq_tb
`default_nettype wire
